// ---- include/psc_regs.svh ----
// Constants for the PWM-synchronised current sensing block
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
`define PSC_DLY_W      16
`define PSC_DLY_ZERO   16'h0000
`define PSC_DLY_ONE    16'h0001
`define PSC_SEC_RST    3'h1
`define PSC_SEC_1      3'h1
`define PSC_SEC_2      3'h2
`define PSC_SEC_3      3'h3
`define PSC_SEC_4      3'h4
`define PSC_SEC_5      3'h5
`define PSC_SEC_6      3'h6
`define PSC_NAVG_LOG2  3
`define PSC_FILT_SHIFT 4
`define PSC_TEMP_B     16'h2759
`define PSC_TEMP_AINV  16'hff79
`define PSC_TEMP_FRAC  4
`endif

// ---- include/psc_pkg.sv ----
// Types for the PWM-synchronised current sensing block
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_IDLE,
    PSC_DELAY,
    PSC_CONV
  } psc_state_e;
  typedef logic signed [15:0] psc_cur_t;
endpackage : psc_pkg

// ---- rtl/psc_sense.sv ----
// PWM-synchronised current, bus voltage and temperature sensing
// What this block does
// - The sync pulse starts the delay timer channel that holds a programmable delay.
// - When the delay expires the block starts an ADC conversion with no processor help.
// - The delay value places sampling at the centre of the centre-aligned PWM period.
// - Two currents are converted and the third makes the three sum to zero.
// - Six sectors exist and the computed current is that of the most positive phase.
// - Sectors 1 and 6 compute A, 2 and 3 compute B, 4 and 5 compute C from the other two.
// - Bus voltage runs through a first-order recursive filter after an N-sample average.
// - Temperature is the diode sample minus b, divided by a.
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_sense
  import psc_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire logic                   pwm_sync,
  input  wire logic [`PSC_DLY_W-1:0]  sync_delay,
  input  wire logic [2:0]             sector,
  input  wire logic                   adc_done,
  input  wire psc_pkg::psc_cur_t      adc_cur_a,
  input  wire psc_pkg::psc_cur_t      adc_cur_b,
  input  wire psc_pkg::psc_cur_t      adc_cur_c,
  input  wire logic [DW-1:0]          adc_bus,
  input  wire logic [DW-1:0]          adc_temp,
  output logic                        adc_start,
  output psc_pkg::psc_cur_t           cur_a,
  output psc_pkg::psc_cur_t           cur_b,
  output psc_pkg::psc_cur_t           cur_c,
  output logic                        cur_valid,
  output logic [DW-1:0]               filtered_bus_voltage,
  output logic                        filt_ready,
  output psc_pkg::psc_cur_t           temp_c
);
  import psc_pkg::*;

  localparam int NAVG = 1 << `PSC_NAVG_LOG2;
  localparam int AW   = DW + `PSC_NAVG_LOG2;

  typedef struct packed {
    psc_state_e              st;
    logic [`PSC_DLY_W-1:0]   cnt;
    logic [2:0]              sec;
    logic                    start;
    psc_cur_t                a;
    psc_cur_t                b;
    psc_cur_t                c;
    logic                    valid;
    logic [AW-1:0]           acc;
    logic [`PSC_NAVG_LOG2:0] n;
    logic [DW-1:0]           filt;
    logic                    ready;
    psc_cur_t                temp;
    logic [2:0]              pin;
    logic                    lvl;
  } psc_state_s;

  psc_state_s r;
  psc_state_s next_r;

  // Pin passes three stages; a level counts once stages two and three agree,
  // so a one-clock glitch never starts a conversion
  logic sync_rise;
  assign sync_rise = r.pin[1] & r.pin[2] & ~r.lvl;

  logic signed [31:0] temp_prod;
  logic signed [DW:0] temp_diff;
  logic signed [DW:0] filt_diff;

  always_comb begin
    next_r       = r;
    next_r.start = 1'b0;
    next_r.valid = 1'b0;
    next_r.pin   = {r.pin[1:0], pwm_sync};
    if (r.pin[1] == r.pin[2]) begin
      next_r.lvl = r.pin[2];
    end
    temp_diff    = $signed({1'b0, adc_temp}) - $signed({1'b0, `PSC_TEMP_B});
    temp_prod    = 32'(temp_diff) * 32'($signed(`PSC_TEMP_AINV));
    filt_diff    = $signed({1'b0, adc_bus}) - $signed({1'b0, r.filt});
    case (r.st)
      PSC_IDLE: begin
        if (sync_rise) begin
          next_r.sec = sector;
          next_r.cnt = sync_delay;
          if (sync_delay == `PSC_DLY_ZERO) begin
            next_r.start = 1'b1;
            next_r.st    = PSC_CONV;
          end else begin
            next_r.st = PSC_DELAY;
          end
        end
      end
      PSC_DELAY: begin
        if (r.cnt == `PSC_DLY_ONE) begin
          next_r.start = 1'b1;
          next_r.st    = PSC_CONV;
        end
        next_r.cnt = r.cnt - `PSC_DLY_ONE;
      end
      PSC_CONV: begin
        if (adc_done) begin
          next_r.st    = PSC_IDLE;
          next_r.valid = 1'b1;
          next_r.a     = adc_cur_a;
          next_r.b     = adc_cur_b;
          next_r.c     = adc_cur_c;
          // Latched sector, not the live one, keeps the set consistent
          if (r.sec == `PSC_SEC_1 || r.sec == `PSC_SEC_6) begin
            next_r.a = -adc_cur_b - adc_cur_c;
          end else if (r.sec == `PSC_SEC_2 || r.sec == `PSC_SEC_3) begin
            next_r.b = -adc_cur_a - adc_cur_c;
          end else if (r.sec == `PSC_SEC_4 || r.sec == `PSC_SEC_5) begin
            next_r.c = -adc_cur_b - adc_cur_a;
          end
          // Start-up average, then recursive filter
          if (!r.ready) begin
            next_r.acc = r.acc + AW'(adc_bus);
            next_r.n   = r.n + 1'b1;
            if (r.n == (`PSC_NAVG_LOG2+1)'(NAVG - 1)) begin
              next_r.filt  = DW'((r.acc + AW'(adc_bus)) >> `PSC_NAVG_LOG2);
              next_r.ready = 1'b1;
            end
          end else begin
            next_r.filt = DW'($signed({1'b0, r.filt}) + (filt_diff >>> `PSC_FILT_SHIFT));
          end
          // Multiply by 1/a in fixed point; avoids a divider
          next_r.temp = 16'(temp_prod >>> `PSC_TEMP_FRAC);
        end
      end
      default: next_r.st = PSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r     <= '0;
      r.st  <= PSC_IDLE;
      r.sec <= `PSC_SEC_RST;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign adc_start            = r.start;
  assign cur_a                = r.a;
  assign cur_b                = r.b;
  assign cur_c                = r.c;
  assign cur_valid            = r.valid;
  assign filtered_bus_voltage = r.filt;
  assign filt_ready           = r.ready;
  assign temp_c               = r.temp;

  property p_sum_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      cur_valid && r.sec inside {[1:6]} |-> 16'(cur_a + cur_b + cur_c) == 16'h0000;
  endproperty
  a_sum_zero: assert property (p_sum_zero) else $error("currents do not sum to zero");

  property p_sec_a;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(r.valid) && (r.sec == 3'h1 || r.sec == 3'h6) |-> cur_b == $past(adc_cur_b);
  endproperty
  a_sec_a: assert property (p_sec_a) else $error("phase B not measured in sector 1/6");

  property p_delay_start;
    @(posedge clk_sys) disable iff (sys_rst)
      clk_en && r.st == PSC_IDLE && sync_rise && sync_delay == 16'h0003
      ##1 clk_en[*3] |=> adc_start;
  endproperty
  a_delay_start: assert property (p_delay_start) else $error("start not after delay");

  property p_start_once;
    @(posedge clk_sys) disable iff (sys_rst)
      adc_start |-> r.st == PSC_CONV;
  endproperty
  a_start_once: assert property (p_start_once) else $error("start outside conversion");

  property p_sec_latch;
    @(posedge clk_sys) disable iff (sys_rst)
      clk_en && r.st == PSC_IDLE && sync_rise |=> r.sec == $past(sector);
  endproperty
  a_sec_latch: assert property (p_sec_latch) else $error("sector not latched");

  property p_ready_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      filt_ready |=> filt_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("filter ready dropped");

  property p_filt_still;
    @(posedge clk_sys) disable iff (sys_rst)
      !cur_valid && $past(!cur_valid) |-> $stable(filtered_bus_voltage);
  endproperty
  a_filt_still: assert property (p_filt_still) else $error("filter moved without sample");

  property p_temp_upd;
    @(posedge clk_sys) disable iff (sys_rst)
      !cur_valid |-> $stable(temp_c);
  endproperty
  a_temp_upd: assert property (p_temp_upd) else $error("temperature moved without sample");

  property p_start_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
      clk_en && adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");

  property p_valid_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
      clk_en && cur_valid |=> !cur_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid not a pulse");

  property p_sync_once;
    @(posedge clk_sys) disable iff (sys_rst)
      clk_en && sync_rise |=> !sync_rise;
  endproperty
  a_sync_once: assert property (p_sync_once) else $error("sync edge taken twice");
endmodule : psc_sense

// ---- test/psc_pwm_adc_model.sv ----
// Far-side model: PWM reload pulse source and ADC conversion answer
`timescale 1ns/10ps
module psc_pwm_adc_model (
  input  wire logic       clk_sys,
  input  wire logic       fire,
  input  wire logic [2:0] lat,
  input  wire logic       adc_start,
  output logic            pwm_sync,
  output logic            adc_done
);
  logic [2:0] busy = 3'h0;
  logic       fire_d = 1'b0;
  initial pwm_sync = 1'b0;
  initial adc_done = 1'b0;
  always @(posedge clk_sys) begin
    fire_d   <= fire;
    // Two clocks wide so the pin filter in the block keeps it
    pwm_sync <= fire | fire_d;
    adc_done <= (busy == 3'h1);
    // Lat of 1 answers at once, 6 is a slow converter
    if (adc_start) busy <= lat;
    else if (busy != 3'h0) busy <= busy - 3'h1;
  end
endmodule : psc_pwm_adc_model

// ---- test/tb.sv ----
// Testbench for the PWM-synchronised sensing block
`timescale 1ns/10ps
module tb;
  import psc_pkg::*;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, fire = 1'b0, clk_en = 1'b1;
  logic        adc_start, adc_done, pwm_sync, cur_valid, filt_ready;
  logic [15:0] sync_delay = 16'h0000, adc_bus = 16'h0000, adc_temp = 16'h0000;
  logic [15:0] filtered_bus_voltage;
  logic [2:0]  sector = 3'h1, lat = 3'h1;
  psc_cur_t    adc_cur_a = 16'h0000, adc_cur_b = 16'h0000, adc_cur_c = 16'h0000;
  psc_cur_t    cur_a, cur_b, cur_c, temp_c;
  int          n_fail = 0, checked = 0, l0, l1, k;
  always #4 clk_sys = ~clk_sys;
  psc_sense i_dut (.clk_sys, .sys_rst, .clk_en, .pwm_sync, .sync_delay, .sector,
    .adc_done, .adc_cur_a, .adc_cur_b, .adc_cur_c, .adc_bus, .adc_temp, .adc_start,
    .cur_a, .cur_b, .cur_c, .cur_valid, .filtered_bus_voltage, .filt_ready, .temp_c);
  psc_pwm_adc_model i_far (.clk_sys, .fire, .lat, .adc_start, .pwm_sync, .adc_done);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // One reload-to-result transfer; sector is disturbed once the sync is taken
  task automatic xfer(input logic [2:0] s, input logic [15:0] d, input logic [15:0] bv,
                      input logic [15:0] tv, output int l);
    int n;
    sector <= s; sync_delay <= d; adc_bus <= bv; adc_temp <= tv; fire <= 1'b1;
    @(posedge clk_sys); fire <= 1'b0; n = 0;
    while (adc_start !== 1'b1 && n < 300) begin @(posedge clk_sys); n++; end
    l = n;
    chk({15'h0, adc_start}, 16'h0001);
    sector <= s ^ 3'h4;
    @(posedge clk_sys); chk({15'h0, adc_start}, 16'h0000);
    n = 0;
    while (cur_valid !== 1'b1 && n < 50) begin @(posedge clk_sys); n++; end
    chk({15'h0, cur_valid}, 16'h0001);
  endtask : xfer
  task automatic t_sectors;
    psc_cur_t ea, eb, ec;
    adc_cur_a <= 16'h0123; adc_cur_b <= 16'hffbb; adc_cur_c <= 16'h0100;
    for (int s = 1; s <= 6; s++) begin
      lat <= s[0] ? 3'h1 : 3'h6;
      xfer(s[2:0], 16'h0000, 16'h0800, 16'h2759, l0);
      ea = 16'h0123; eb = 16'hffbb; ec = 16'h0100;
      if (s == 1 || s == 6) ea = -eb - ec;
      else if (s <= 3) eb = -ea - ec;
      else ec = -ea - eb;
      chk(cur_a, ea);
      chk(cur_b, eb);
      chk(cur_c, ec);
      chk(temp_c, 16'h0000);
    end
  endtask : t_sectors
  // Delay scaling and start-up average then recursive smoothing
  task automatic t_delay_filter;
    xfer(3'h1, 16'h0000, 16'h0800, 16'h2759, l0);
    chk({15'h0, filt_ready}, 16'h0000);
    xfer(3'h1, 16'h0014, 16'h0800, 16'h2759, l1);
    chk(16'(l1 - l0), 16'h0014);
    chk({15'h0, filt_ready}, 16'h0001);
    chk(filtered_bus_voltage, 16'h0800);
    xfer(3'h2, 16'h0000, 16'h0900, 16'h2769, l0);
    chk(filtered_bus_voltage, 16'h0810);
    chk(temp_c, 16'hff79);
    xfer(3'h4, 16'h0003, 16'h0900, 16'h2769, k);
    chk(16'(k - l0), 16'h0003);
    chk(filtered_bus_voltage, 16'h081f);
  endtask : t_delay_filter
  // A second reload during the delay must neither start nor restart a conversion
  task automatic t_refuse;
    int lr;
    sync_delay <= 16'h0014; fire <= 1'b1;
    @(posedge clk_sys); fire <= 1'b0; k = 0; lr = 0;
    for (int i = 1; i <= 100; i++) begin
      @(posedge clk_sys);
      if (i == 6) fire <= 1'b1;
      if (i == 7) fire <= 1'b0;
      if (adc_start === 1'b1) begin
        k++;
        lr = i;
      end
    end
    chk(16'(k), 16'h0001);
    chk(16'(lr), 16'(l1));
  endtask : t_refuse
  // Clock enable low in the delay stretches it by exactly the frozen cycles
  task automatic t_freeze;
    int n;
    sync_delay <= 16'h0014; fire <= 1'b1;
    @(posedge clk_sys); fire <= 1'b0; n = 0;
    while (adc_start !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
      if (n == 8) clk_en <= 1'b0;
      if (n == 13) clk_en <= 1'b1;
    end
    chk(16'(n), 16'(l1 + 5));
    n = 0;
    while (cur_valid !== 1'b1 && n < 50) begin @(posedge clk_sys); n++; end
    chk({15'h0, cur_valid}, 16'h0001);
  endtask : t_freeze
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk(cur_a, 16'h0000);
    chk({15'h0, cur_valid}, 16'h0000);
    t_sectors;
    t_delay_filter;
    t_refuse;
    t_freeze;
    report_and_stop;
  end
  // Whole run is well under 3000 cycles
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule : tb
